// ### hw/clock_ctl_map.svh
// Register map, field positions, reset values and counts of the clock
// control block. Assumes a 32-bit Avalon-MM bus with byte addresses.
`ifndef CLOCK_CTL_MAP_SVH
`define CLOCK_CTL_MAP_SVH

// Byte offsets
`define OFS_OSC_CTRL 5'h00
`define OFS_CLK_DIV 5'h04
`define OFS_PLL_FBD 5'h08
`define OFS_RC_TUNE 5'h0C
`define OFS_UNLOCK 5'h10

// Unlock keys, written in turn to the unlock register
`define UNLOCK_KEY1 8'h55
`define UNLOCK_KEY2 8'hAA

// Oscillator control fields
`define OSC_CUR_LSB 12
`define OSC_NXT_LSB 8
`define OSC_LOCK_BIT 5
`define OSC_CF_BIT 3
`define OSC_SEC_BIT 1
`define OSC_REQ_BIT 0

// Reset values
`define RST_DOZE 3'h3
`define RST_POST 2'h1
`define RST_PRE 5'h00
`define RST_FBD 9'h030

// Source codes
`define SRC_FRC 3'h0
`define SRC_FRC_PLL 3'h1
`define SRC_PRI 3'h2
`define SRC_PRI_PLL 3'h3
`define SRC_SEC 3'h4
`define SRC_LOW_POWER_INTERNAL_RC 3'h5

// New-clock cycles counted before the switch
`define SETTLE_CYCLES 4'hA

`endif

// ### hw/clock_ctl_pkg.sv
// Types of the clock control block: switch states and the state record.
// Assumes nothing of its surroundings.
package clock_ctl_pkg;

typedef enum logic [2:0] {SW_IDLE, SW_CHECK, SW_START, SW_SETTLE, SW_DONE}
    sw_state_t;

typedef struct packed {
    sw_state_t fsm;
    logic [3:0] cnt;
    logic [2:0] cur;
    logic [2:0] nxt;
    logic [2:0] target;
    logic lock;
    logic cf;
    logic sec_en;
    logic req;
    logic recover_on_interrupt;
    logic [2:0] doze;
    logic doze_en;
    logic [2:0] frcdiv;
    logic [1:0] post;
    logic [4:0] pre;
    logic [8:0] fbd;
    logic [5:0] tun;
    logic init;
    logic key1;
    logic armed;
    logic waitreq;
    logic [31:0] rdata;
    logic [2:0] sel;
    logic en_frc;
    logic en_pri;
    logic en_sec;
    logic en_low_power_internal_rc;
    logic en_pll;
    logic trap;
    logic [2:0] cpu_shift;
    logic [3:0] rc_shift;
    logic [5:0] n1;
    logic [3:0] n2;
    logic [9:0] m;
    logic [5:0] trim;
    logic [1:0] submode;
} ctl_state_t;

endpackage : clock_ctl_pkg

// ### hw/clock_divider_switch_failsafe.sv
// Clock divider, oscillator switch sequencer and fail-safe monitor.
// Assumes oscillator status inputs are synchronous to clock and that
// new_clock_tick pulses once per cycle of the incoming source.
//
// Notes on behaviour
// - With recover-on-interrupt set, an interrupt clears doze and restores 1:1.
// - Doze field divides processor clock by two to its power; resets to 3.
// - Doze disabled forces the processor to peripheral ratio to 1:1.
// - Fast RC postscaler divides by 1 to 64, code 7 by 256.
// - PLL post divider: 00 by 2, 01 by 4, 11 by 8, 10 reserved.
// - PLL pre divider divides by field value plus two.
// - PLL feedback multiplier is field plus two, resets to 50.
// - Six-bit signed RC tuning trims fast RC in 0.375 percent steps.
// - Switching and fail-safe monitor work only when the config bit is 0.
// - Switching disabled: next source ignored, current shows initial config.
// - Switching disabled: switch request held at zero.
// - Request with next equal to current clears request and aborts.
// - A valid switch first clears lock status and clock fail flag.
// - Start the new source, wait start-up and PLL lock as needed.
// - Count ten new-clock cycles before switching over.
// - On completion clear request and copy next into current source.
// - Turn off old source, keeping LOW_POWER_INTERNAL_RC and secondary where required.
// - Primary submode stays fixed by configuration bits.
// - Monitor enabled keeps LOW_POWER_INTERNAL_RC running except in sleep.
// - On failure raise trap and fall back to fast RC, keeping PLL.
// - Source codes: FAST_INTERNAL_RC, FAST_INTERNAL_RC PLL, primary, primary PLL, SOSC, LOW_POWER_INTERNAL_RC, /16, /N.
// - Monitor sets clock fail flag; software reads and clears it.
//
// The implementer's own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "clock_ctl_map.svh"

module clock_divider_switch_failsafe
    import clock_ctl_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Avalon-MM slave
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Configuration bits
    input wire logic switch_monitor_config,
    input wire logic [2:0] initial_source_config,
    input wire logic [1:0] primary_submode_config,
    input wire logic watchdog_enabled,
    // Oscillator, PLL and core status
    input wire logic source_ready,
    input wire logic pll_locked,
    input wire logic new_clock_tick,
    input wire logic clock_failure,
    input wire logic interrupt_event,
    input wire logic sleep_mode,
    // Source selection and enables
    output logic [2:0] system_source_select,
    output logic fast_rc_enable,
    output logic primary_osc_enable,
    output logic secondary_osc_run,
    output logic low_power_rc_enable,
    output logic pll_enable,
    output logic [1:0] primary_submode,
    output logic clock_fail_trap,
    // Divider settings
    output logic [2:0] cpu_clock_shift,
    output logic [3:0] rc_postscale_shift,
    output logic [5:0] pll_prescale,
    output logic [3:0] pll_postscale,
    output logic [9:0] pll_multiplier,
    output logic [5:0] rc_trim
);

// ---------------------------------------------------------------
// Helpers
// ---------------------------------------------------------------
// Mask {pll, low_power_internal_rc, sec, pri, frc} of resources a source needs
function automatic logic [4:0] src_mask(input logic [2:0] code);
    logic [4:0] m;
    case (code)
        `SRC_FRC_PLL: m = 5'h11;
        `SRC_PRI: m = 5'h02;
        `SRC_PRI_PLL: m = 5'h12;
        `SRC_SEC: m = 5'h04;
        `SRC_LOW_POWER_INTERNAL_RC: m = 5'h08;
        default: m = 5'h01;
    endcase
    return m;
endfunction : src_mask

function automatic logic frc_based(input logic [2:0] code);
    return code[2:1] == 2'h0 || code[2:1] == 2'h3;
endfunction : frc_based

ctl_state_t r;
ctl_state_t n;
logic [31:0] rd;
logic [4:0] need;
logic wr;
logic sw_on;
logic monitor_on;

assign sw_on = !switch_monitor_config;
assign monitor_on = !switch_monitor_config;
assign wr = write && !r.waitreq;

// ---------------------------------------------------------------
// Read mux
// ---------------------------------------------------------------
always_comb
begin
    rd = 32'h0000_0000;
    if (address == `OFS_OSC_CTRL)
    begin
        rd[`OSC_CUR_LSB +: 3] = r.cur;
        rd[`OSC_NXT_LSB +: 3] = r.nxt;
        rd[`OSC_LOCK_BIT] = r.lock;
        rd[`OSC_CF_BIT] = r.cf;
        rd[`OSC_SEC_BIT] = r.sec_en;
        rd[`OSC_REQ_BIT] = r.req;
    end
    else if (address == `OFS_CLK_DIV)
        rd[15:0] = {r.recover_on_interrupt, r.doze, r.doze_en, r.frcdiv, r.post, 1'b0, r.pre};
    else if (address == `OFS_PLL_FBD)
        rd[8:0] = r.fbd;
    else if (address == `OFS_RC_TUNE)
        rd[5:0] = r.tun;
end

// ---------------------------------------------------------------
// Next state
// ---------------------------------------------------------------
always_comb
begin
    n = r;
    n.trap = 1'b0;
    // One wait cycle per access; answer registered with it
    n.waitreq = !((read || write) && r.waitreq);
    if ((read || write) && r.waitreq)
        n.rdata = read ? rd : 32'h0000_0000;

    // Lock status follows the PLL while it is enabled
    n.lock = pll_locked && r.en_pll;

    if (wr)
    begin
        n.key1 = 1'b0;
        n.armed = 1'b0;
        if (address == `OFS_UNLOCK)
        begin
            if (writedata[7:0] == `UNLOCK_KEY1)
                n.key1 = 1'b1;
            else if (r.key1 && writedata[7:0] == `UNLOCK_KEY2)
                n.armed = 1'b1;
        end
        else if (address == `OFS_OSC_CTRL)
        begin
            if (r.armed)
            begin
                if (byteenable[1])
                    n.nxt = writedata[`OSC_NXT_LSB +: 3];
                if (byteenable[0])
                begin
                    n.sec_en = writedata[`OSC_SEC_BIT];
                    if (!writedata[`OSC_CF_BIT])
                        n.cf = 1'b0;
                    if (writedata[`OSC_REQ_BIT] && sw_on)
                        n.req = 1'b1;
                end
            end
        end
        else if (address == `OFS_CLK_DIV)
        begin
            if (byteenable[1])
            begin
                n.recover_on_interrupt = writedata[15];
                n.doze = writedata[14:12];
                n.doze_en = writedata[11];
                n.frcdiv = writedata[10:8];
            end
            if (byteenable[0])
            begin
                n.post = writedata[7:6];
                n.pre = writedata[4:0];
            end
        end
        else if (address == `OFS_PLL_FBD)
        begin
            if (byteenable[1])
                n.fbd[8] = writedata[8];
            if (byteenable[0])
                n.fbd[7:0] = writedata[7:0];
        end
        else if (address == `OFS_RC_TUNE)
        begin
            if (byteenable[0])
                n.tun = writedata[5:0];
        end
    end

    // Hardware recovery beats a coincident software write
    if (interrupt_event && r.recover_on_interrupt)
        n.doze_en = 1'b0;

    // Switch sequencer
    case (r.fsm)
        SW_IDLE:
        begin
            if (r.req)
                n.fsm = SW_CHECK;
        end
        SW_CHECK:
        begin
            if (r.nxt == r.cur)
            begin
                n.req = 1'b0;
                n.fsm = SW_IDLE;
            end
            else
            begin
                n.lock = 1'b0;
                n.cf = 1'b0;
                n.target = r.nxt;
                n.fsm = SW_START;
            end
        end
        SW_START:
        begin
            // Source ready covers start-up timer for crystals
            if (source_ready && (r.target[2] || !r.target[0] || pll_locked))
            begin
                n.cnt = 4'h0;
                n.fsm = SW_SETTLE;
            end
        end
        SW_SETTLE:
        begin
            if (new_clock_tick)
            begin
                n.cnt = r.cnt + 4'h1;
                if (r.cnt == `SETTLE_CYCLES - 4'h1)
                    n.fsm = SW_DONE;
            end
        end
        SW_DONE:
        begin
            n.cur = r.target;
            n.req = 1'b0;
            n.fsm = SW_IDLE;
        end
        default: n.fsm = SW_IDLE;
    endcase

    // Fail-safe: flag set wins over any clear this cycle
    if (monitor_on && clock_failure && !sleep_mode && !frc_based(r.cur))
    begin
        n.cf = 1'b1;
        n.trap = 1'b1;
        n.cur = (!r.cur[2] && r.cur[0]) ? `SRC_FRC_PLL : `SRC_FRC;
        n.req = 1'b0;
        n.fsm = SW_IDLE;
    end

    // Straps caught once after reset release
    if (r.init)
    begin
        n.init = 1'b0;
        n.nxt = initial_source_config;
        n.submode = primary_submode_config;
    end
    if (!sw_on || r.init)
    begin
        n.cur = initial_source_config;
        n.req = 1'b0;
        n.fsm = SW_IDLE;
    end

    // Old source drops once current moves on
    need = src_mask(n.cur);
    if (n.fsm == SW_START || n.fsm == SW_SETTLE || n.fsm == SW_DONE)
        need = need | src_mask(n.target);
    n.sel = n.cur;
    n.en_frc = need[0];
    n.en_pri = need[1];
    n.en_sec = need[2] || n.sec_en;
    n.en_low_power_internal_rc = need[3] || watchdog_enabled || (monitor_on && !sleep_mode);
    n.en_pll = need[4];

    // Divider outputs
    n.cpu_shift = n.doze_en ? n.doze : 3'h0;
    n.rc_shift = (n.frcdiv == 3'h7) ? 4'h8 : {1'b0, n.frcdiv};
    n.n1 = {1'b0, n.pre} + 6'h02;
    case (n.post)
        2'h0: n.n2 = 4'h2;
        2'h3: n.n2 = 4'h8;
        default: n.n2 = 4'h4;
    endcase
    n.m = {1'b0, n.fbd} + 10'h002;
    n.trim = n.tun;
end

// ---------------------------------------------------------------
// State register
// ---------------------------------------------------------------
always_ff @(posedge clock)
begin
    if (reset)
    begin
        r <= '0;
        r.fsm <= SW_IDLE;
        r.doze <= `RST_DOZE;
        r.post <= `RST_POST;
        r.pre <= `RST_PRE;
        r.fbd <= `RST_FBD;
        r.init <= 1'b1;
        r.waitreq <= 1'b1;
        r.en_frc <= 1'b1;
        r.n1 <= 6'h02;
        r.n2 <= 4'h4;
        r.m <= 10'h032;
    end
    else
        r <= n;
end

assign readdata = r.rdata;
assign waitrequest = r.waitreq;
assign system_source_select = r.sel;
assign fast_rc_enable = r.en_frc;
assign primary_osc_enable = r.en_pri;
assign secondary_osc_run = r.en_sec;
assign low_power_rc_enable = r.en_low_power_internal_rc;
assign pll_enable = r.en_pll;
assign primary_submode = r.submode;
assign clock_fail_trap = r.trap;
assign cpu_clock_shift = r.cpu_shift;
assign rc_postscale_shift = r.rc_shift;
assign pll_prescale = r.n1;
assign pll_postscale = r.n2;
assign pll_multiplier = r.m;
assign rc_trim = r.trim;

// ---------------------------------------------------------------
// Assertions
// ---------------------------------------------------------------
default clocking cb @(posedge clock); endclocking
default disable iff (reset);

a_doze_recover: assert property (
    interrupt_event && r.recover_on_interrupt |=> !r.doze_en && cpu_clock_shift == 3'h0)
    else $error("doze not cleared by interrupt");
a_ratio_forced: assert property (
    !r.doze_en && !wr |=> cpu_clock_shift == 3'h0)
    else $error("ratio not 1:1 with doze off");
a_rc_post: assert property (
    r.frcdiv == 3'h7 |-> rc_postscale_shift == 4'h8)
    else $error("rc postscaler code 7 wrong");
a_pll_pre: assert property (
    pll_prescale == {1'b0, r.pre} + 6'h02)
    else $error("pll prescale wrong");
a_req_held: assert property (
    switch_monitor_config |=> !r.req)
    else $error("request set while switching disabled");
a_redundant: assert property (
    r.fsm == SW_CHECK && r.nxt == r.cur |=> !r.req && r.fsm == SW_IDLE)
    else $error("redundant switch not aborted");
a_status_clear: assert property (
    r.fsm == SW_CHECK && r.nxt != r.cur && !clock_failure
    |=> !r.lock && !r.cf)
    else $error("status not cleared on switch");
a_start_wait: assert property (r.fsm == SW_START && !source_ready
    |=> r.fsm != SW_SETTLE) else $error("switch ran before source ready");
a_settle_count: assert property (
    r.fsm == SW_DONE |-> r.cnt == `SETTLE_CYCLES)
    else $error("settle count wrong");
a_switch_done: assert property (
    r.fsm == SW_DONE && !clock_failure |=> r.cur == $past(r.target)
    && !r.req && system_source_select == $past(r.target))
    else $error("switch did not complete");
a_fail_trap: assert property (
    !switch_monitor_config && clock_failure && !sleep_mode
    && !frc_based(r.cur) && !r.init |=> clock_fail_trap && r.cf
    && frc_based(r.cur))
    else $error("fail-safe fallback missing");
a_guard_write: assert property (
    wr && address == `OFS_OSC_CTRL && !r.armed && !r.init
    |=> r.nxt == $past(r.nxt))
    else $error("unguarded write took effect");

c_switch: cover property (r.fsm == SW_DONE);
c_abort: cover property (r.fsm == SW_CHECK && r.nxt == r.cur);
c_trap: cover property (clock_fail_trap);
c_recover: cover property (interrupt_event && r.recover_on_interrupt && r.doze_en);

endmodule : clock_divider_switch_failsafe

// ### verif/osc_source_model.sv
// Behavioural oscillator and PLL model facing the clock control block.
// Assumes the enables come from the design, synchronous to clock.
`timescale 1ns/1ns

module osc_source_model #(
    parameter int START_DELAY = 6,
    parameter int LOCK_DELAY = 9
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Enables from the design
    input wire logic [3:0] osc_enables,
    input wire logic pll_enable,
    // Status to the design
    output logic source_ready,
    output logic pll_locked,
    output logic new_clock_tick
);
    logic [3:0] en_reg;
    int run_cnt;
    int lock_cnt;
    int tick_cnt;

    // Start-up timer restarts whenever a source is turned on
    always @(posedge clock)
    begin
        en_reg <= osc_enables;
        if (reset || (osc_enables & ~en_reg) != 4'h0)
            run_cnt <= 0;
        else if (run_cnt < START_DELAY)
            run_cnt <= run_cnt + 1;
        // Lock is lost at once when the PLL is turned off
        if (reset || !pll_enable)
            lock_cnt <= 0;
        else if (lock_cnt < LOCK_DELAY)
            lock_cnt <= lock_cnt + 1;
        tick_cnt <= (reset || tick_cnt == 2) ? 0 : tick_cnt + 1;
    end

    // Not ready in the cycle a source is newly turned on
    assign source_ready = run_cnt >= START_DELAY
        && (osc_enables & ~en_reg) == 4'h0;
    assign pll_locked = lock_cnt >= LOCK_DELAY;
    assign new_clock_tick = tick_cnt == 0 && osc_enables != 4'h0;
endmodule : osc_source_model

// ### verif/tb_top.sv
// Self-checking bench for the clock control block.
// Assumes the map header is on the include path.
`timescale 1ns/1ns
`include "clock_ctl_map.svh"

module tb_top;
    logic clock, reset, read, write, waitrequest;
    logic [4:0] address;
    logic [31:0] writedata, readdata, q;
    logic [3:0] byteenable;
    logic switch_monitor_config, watchdog_enabled, source_ready;
    logic [2:0] initial_source_config, system_source_select;
    logic pll_locked, new_clock_tick, clock_failure, interrupt_event;
    logic sleep_mode;
    logic fast_rc_enable, primary_osc_enable, secondary_osc_run;
    logic low_power_rc_enable, pll_enable, clock_fail_trap;
    logic [1:0] primary_submode, submode_cfg;
    logic [2:0] cpu_clock_shift;
    logic [3:0] rc_postscale_shift, pll_postscale;
    logic [5:0] pll_prescale, rc_trim;
    logic [9:0] pll_multiplier;
    int error_cnt = 0;
    int samples_checked = 0;
    int trap_cnt = 0;

    typedef struct packed {
        logic [15:0] div;
        logic [2:0] cpu;
        logic [3:0] rc;
        logic [5:0] n1;
        logic [3:0] n2;
    } row_t;
    row_t rows [8] = '{
        '{16'h0800, 3'h0, 4'h0, 6'h02, 4'h2},
        '{16'h1941, 3'h1, 4'h1, 6'h03, 4'h4},
        '{16'h2A85, 3'h2, 4'h2, 6'h07, 4'h4},
        '{16'h3BDF, 3'h3, 4'h3, 6'h21, 4'h8},
        '{16'h4C02, 3'h4, 4'h4, 6'h04, 4'h2},
        '{16'h5D50, 3'h5, 4'h5, 6'h12, 4'h4},
        '{16'h6E9E, 3'h6, 4'h6, 6'h20, 4'h4},
        '{16'h7FDF, 3'h7, 4'h8, 6'h21, 4'h8}};

    clock_divider_switch_failsafe u_clock_divider_switch_failsafe (
        .clock(clock), .reset(reset), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest),
        .switch_monitor_config(switch_monitor_config),
        .initial_source_config(initial_source_config),
        .primary_submode_config(submode_cfg),
        .watchdog_enabled(watchdog_enabled),
        .source_ready(source_ready), .pll_locked(pll_locked),
        .new_clock_tick(new_clock_tick), .clock_failure(clock_failure),
        .interrupt_event(interrupt_event), .sleep_mode(sleep_mode),
        .system_source_select(system_source_select),
        .fast_rc_enable(fast_rc_enable),
        .primary_osc_enable(primary_osc_enable),
        .secondary_osc_run(secondary_osc_run),
        .low_power_rc_enable(low_power_rc_enable),
        .pll_enable(pll_enable), .primary_submode(primary_submode),
        .clock_fail_trap(clock_fail_trap), .cpu_clock_shift(cpu_clock_shift),
        .rc_postscale_shift(rc_postscale_shift), .pll_prescale(pll_prescale),
        .pll_postscale(pll_postscale), .pll_multiplier(pll_multiplier),
        .rc_trim(rc_trim));

    osc_source_model u_osc_source_model (
        .clock(clock), .reset(reset),
        .osc_enables({primary_osc_enable, secondary_osc_run,
                      low_power_rc_enable, fast_rc_enable}),
        .pll_enable(pll_enable), .source_ready(source_ready),
        .pll_locked(pll_locked), .new_clock_tick(new_clock_tick));

    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    always @(posedge clock)
        if (clock_fail_trap === 1'b1)
            trap_cnt++;

    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    task automatic idle(input int n);
        repeat (n) @(posedge clock);
    endtask : idle

    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [31:0] d, input logic [3:0] be);
        int n = 0;
        @(posedge clock);
        address <= a;
        write <= w;
        read <= !w;
        writedata <= d;
        byteenable <= be;
        @(posedge clock);
        while (waitrequest !== 1'b0 && n < 20)
        begin
            @(posedge clock);
            n++;
        end
        if (n == 20)
            error_cnt++;
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask : bus

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD reg t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_pin(input logic [9:0] got, input logic [9:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD pin t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_pin

    task automatic wr_rd(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'h3);
        bus(1'b0, a, 32'h0000_0000, 4'hF);
        idle(2);
    endtask : wr_rd

    task automatic unlock;
        bus(1'b1, `OFS_UNLOCK, 32'h0000_0055, 4'h1);
        bus(1'b1, `OFS_UNLOCK, 32'h0000_00AA, 4'h1);
    endtask : unlock

    // Request write keeps the fail flag bit at 1 so it does not clear it
    task automatic switch_to(input logic [2:0] src);
        int n = 0;
        unlock();
        bus(1'b1, `OFS_OSC_CTRL, {21'h0, src, 8'h00}, 4'h2);
        unlock();
        bus(1'b1, `OFS_OSC_CTRL, 32'h0000_0009, 4'h1);
        q = 32'h0000_0001;
        while (q[0] !== 1'b0 && n < 200)
        begin
            bus(1'b0, `OFS_OSC_CTRL, 32'h0000_0000, 4'hF);
            n++;
        end
        if (q[0] !== 1'b0)
            error_cnt++;
        idle(3);
    endtask : switch_to

    task automatic do_reset(input logic cfg, input logic [2:0] init);
        switch_monitor_config <= cfg;
        initial_source_config <= init;
        reset <= 1'b1;
        idle(2);
        reset <= 1'b0;
        idle(2);
    endtask : do_reset

    task automatic summarize;
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : summarize

    initial
    begin
        #(20 * 30000);
        error_cnt++;
        summarize();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        {reset, read, write, clock_failure, interrupt_event} = 5'h10;
        {sleep_mode, submode_cfg} = 3'h1;
        {address, writedata, byteenable, watchdog_enabled} = '0;
        switch_monitor_config = 1'b0;
        initial_source_config = 3'h0;
        do_reset(1'b0, 3'h0);
        bus(1'b0, `OFS_CLK_DIV, 32'h0000_0000, 4'hF);
        chk_reg(q, 32'h0000_3040);
        bus(1'b0, `OFS_PLL_FBD, 32'h0000_0000, 4'hF);
        chk_reg(q, 32'h0000_0030);
        chk_pin(10'(pll_multiplier), 10'h032);
        chk_pin(10'(pll_prescale), 10'h002);
        chk_pin(10'(pll_postscale), 10'h004);
        chk_pin(10'(rc_postscale_shift), 10'h000);
        chk_pin(10'(primary_submode), 10'h001);
        submode_cfg <= 2'h2;
        for (int i = 0; i < 8; i++)
        begin
            wr_rd(`OFS_CLK_DIV, {16'h0000, rows[i].div});
            chk_reg(q, {16'h0000, rows[i].div});
            chk_pin(10'(cpu_clock_shift), 10'(rows[i].cpu));
            chk_pin(10'(rc_postscale_shift), 10'(rows[i].rc));
            chk_pin(10'(pll_prescale), 10'(rows[i].n1));
            chk_pin(10'(pll_postscale), 10'(rows[i].n2));
        end
        chk_pin(10'(primary_submode), 10'h001);
        wr_rd(`OFS_CLK_DIV, 32'h0000_5040);
        chk_pin(10'(cpu_clock_shift), 10'h000);
        // Interrupt with and without recovery enabled
        for (int r = 0; r < 2; r++)
        begin
            wr_rd(`OFS_CLK_DIV, r == 0 ? 32'h0000_C840 : 32'h0000_4840);
            interrupt_event <= 1'b1;
            idle(1);
            interrupt_event <= 1'b0;
            bus(1'b0, `OFS_CLK_DIV, 32'h0000_0000, 4'hF);
            idle(2);
            chk_reg(q, r == 0 ? 32'h0000_C040 : 32'h0000_4840);
            chk_pin(10'(cpu_clock_shift), r == 0 ? 10'h000 : 10'h004);
        end
        wr_rd(`OFS_PLL_FBD, 32'h0000_FFFF);
        chk_reg(q, 32'h0000_01FF);
        chk_pin(pll_multiplier, 10'h201);
        wr_rd(`OFS_RC_TUNE, 32'h0000_FFE0);
        chk_reg(q, 32'h0000_0020);
        chk_pin(10'(rc_trim), 10'h020);
        wr_rd(5'h14, 32'h0000_FFFF);
        chk_reg(q, 32'h0000_0000);
        // Guarded byte written without the unlock keys
        bus(1'b1, `OFS_OSC_CTRL, 32'h0000_0500, 4'h2);
        bus(1'b0, `OFS_OSC_CTRL, 32'h0000_0000, 4'hF);
        chk_pin(10'(q[10:8]), 10'h000);
        idle(2);
        switch_to(`SRC_PRI);
        chk_pin(10'(q[14:12]), 10'h002);
        chk_pin(10'(system_source_select), 10'h002);
        chk_pin(10'(fast_rc_enable), 10'h000);
        chk_pin(10'(low_power_rc_enable), 10'h001);
        chk_pin(10'(primary_osc_enable), 10'h001);
        // Sleep stops the monitor and its hold on the low-power RC
        sleep_mode <= 1'b1;
        clock_failure <= 1'b1;
        idle(2);
        chk_pin(10'(low_power_rc_enable), 10'h000);
        chk_pin(10'(trap_cnt), 10'h000);
        watchdog_enabled <= 1'b1;
        idle(2);
        chk_pin(10'(low_power_rc_enable), 10'h001);
        {sleep_mode, clock_failure, watchdog_enabled} <= 3'h0;
        idle(2);
        switch_to(`SRC_PRI);
        chk_pin(10'(q[14:12]), 10'h002);
        switch_to(`SRC_PRI_PLL);
        chk_pin(10'(q[14:12]), 10'h003);
        chk_pin(10'(q[5]), 10'h001);
        chk_pin(10'(pll_enable), 10'h001);
        clock_failure <= 1'b1;
        idle(3);
        clock_failure <= 1'b0;
        bus(1'b0, `OFS_OSC_CTRL, 32'h0000_0000, 4'hF);
        idle(2);
        chk_pin(10'(trap_cnt), 10'h001);
        chk_pin(10'(q[14:12]), 10'h001);
        chk_pin(10'(q[3]), 10'h001);
        chk_pin(10'(system_source_select), 10'h001);
        switch_to(`SRC_FRC);
        chk_pin(10'(q[14:12]), 10'h000);
        chk_pin(10'(q[3]), 10'h000);
        chk_pin(10'(pll_enable), 10'h000);
        chk_pin(10'(fast_rc_enable), 10'h001);
        unlock();
        bus(1'b1, `OFS_OSC_CTRL, 32'h0000_000A, 4'h1);
        idle(2);
        chk_pin(10'(secondary_osc_run), 10'h001);
        // Switching and monitor disabled by the strap
        do_reset(1'b1, `SRC_SEC);
        switch_to(`SRC_PRI);
        chk_pin(10'(q[14:12]), 10'h004);
        chk_pin(10'(q[0]), 10'h000);
        chk_pin(10'(system_source_select), 10'h004);
        chk_pin(10'(primary_submode), 10'h002);
        clock_failure <= 1'b1;
        idle(4);
        clock_failure <= 1'b0;
        chk_pin(10'(trap_cnt), 10'h001);
        summarize();
    end
endmodule : tb_top
